// ---- include/ccg_regs.vh ----
`ifndef CCG_REGS_VH
`define CCG_REGS_VH

// Register byte offsets
`define CCG_OFS_PWR      12'h000
`define CCG_OFS_SEL0     12'h004
`define CCG_OFS_TICK     12'h008
`define CCG_OFS_DIV      12'h00c
`define CCG_OFS_PCLK     12'h010
`define CCG_OFS_STAT     12'h014

// power_control_reg fields
`define CCG_PWR_FXT_EN   0
`define CCG_PWR_SXT_EN   1
`define CCG_PWR_RC22_EN  2
`define CCG_PWR_RC48_EN  3
`define CCG_PWR_SRC_EN   4
`define CCG_PWR_PD_EN    7
`define CCG_PWR_WAIT     8
`define CCG_PWR_RST      9'h014

// clock_select_reg0 fields
`define CCG_SEL_SYS_LO   0
`define CCG_SEL_SYS_HI   2
`define CCG_SEL_TICK_LO  3
`define CCG_SEL_TICK_HI  5
`define CCG_SEL_PLLREF   6
`define CCG_SEL0_RST     7'h07

// tick_timer_control field
`define CCG_TICK_CPU     2
`define CCG_TICK_RST     3'h4

// divider_control_reg fields
`define CCG_DIV_N_LO     0
`define CCG_DIV_N_HI     3
`define CCG_DIV_EN       4
`define CCG_DIV_BYP      5
`define CCG_DIV_RST      6'h00

// Peripheral clock register: [3:0] enable, [7:4] low-speed source
`define CCG_PCLK_RST     8'h00
`define CCG_NPER         4

// Source indices of the synchroniser bank
`define CCG_SRC_FXT      0
`define CCG_SRC_SXT      1
`define CCG_SRC_PLL      2
`define CCG_SRC_RC22     3
`define CCG_SRC_RC48     4
`define CCG_SRC_SRC      5
`define CCG_SRC_DIVIN    6
`define CCG_SRC_WAKE     7
`define CCG_NSYNC        8

// Divider chain length
`define CCG_DIV_STAGES   16

`endif

// ---- design/ccg_gfmux.v ----
`include "ccg_regs.vh"

// Four-to-one source switch on sampled clock levels.
module ccg_gfmux (
  input  wire       mclk,
  input  wire       rst,
  input  wire [3:0] src_lvl,
  input  wire [1:0] sel,
  output reg        clk_out_q
);

  reg  [1:0] cur_q;
  wire       switch_ok;

  // Hand over only while both old output and new source sit low,
  // so no shortened high phase can appear
  assign switch_ok = (sel != cur_q) && !clk_out_q && !src_lvl[sel];

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      cur_q     <= 2'h0;
      clk_out_q <= 1'b0;
    end else begin
      if (switch_ok) begin
        cur_q     <= sel;
        clk_out_q <= 1'b0;
      end else begin
        clk_out_q <= src_lvl[cur_q];
      end
    end
  end

endmodule // ccg_gfmux

// ---- design/ccg_fdiv.v ----
`include "ccg_regs.vh"

// Power-of-2 divider with stop-at-low and bypass.
module ccg_fdiv (
  input  wire       mclk,
  input  wire       rst,
  input  wire       in_lvl,
  input  wire       enable,
  input  wire       bypass,
  input  wire [3:0] ratio,
  output reg        clk_out_q
);

  reg  [`CCG_DIV_STAGES-1:0] chain_q;
  reg                        in_prev_q;
  reg                        running_q;
  wire                       in_rise;
  wire                       stage_out;

  assign in_rise   = in_lvl && !in_prev_q;
  // Bit n of the count toggles at Fin / 2^(n+1)
  assign stage_out = chain_q[ratio];

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      chain_q   <= {`CCG_DIV_STAGES{1'b0}};
      in_prev_q <= 1'b0;
      running_q <= 1'b0;
      clk_out_q <= 1'b0;
    end else begin
      in_prev_q <= in_lvl;
      if (enable)
        running_q <= 1'b1;
      else if (running_q && !stage_out)
        running_q <= 1'b0;
      if ((enable || running_q) && in_rise)
        chain_q <= chain_q + {{(`CCG_DIV_STAGES-1){1'b0}}, 1'b1};
      if (bypass)
        clk_out_q <= in_lvl & enable;
      else if (running_q)
        clk_out_q <= stage_out;
      else
        clk_out_q <= 1'b0;
    end
  end

endmodule // ccg_fdiv

// ---- design/ccg_top.v ----
// Overview of operation
// - Enter power-down on wait-for-interrupt only with both power bits set.
// - Stay in power-down until a wake-up interrupt arrives, then leave.
// - Power-down stops the fast crystal and both fast RC oscillators.
// - Provide clock gating, source selection and division for clocks.
// - Six clock sources: two crystals, PLL, two fast RCs, slow RC.
// - PLL reference selects fast crystal or the 22 MHz RC oscillator.
// - System clock picks one of four sources by select bits 2..0.
// - Tick timer runs on CPU clock or external tick clock, bit 2.
// - External tick clock picks one of four sources by bits 5..3.
// - Slow RC and slow crystal keep running during power-down.
// - In power-down peripheral clocks live only on low-speed sources.
// - Sixteen chained halving stages, one routed out by a mux.
// - Output frequency is input over two to the power N plus one.
// - Writing divider enable one starts the chain counting.
// - Clearing enable runs the chain until output low, then holds low.
// - Bypass bit with enable set sends the divider input straight to the output pin; with enable clear the pin stays low.
//
// The register addresses and the APB interface to the registers were decided locally.
`include "ccg_regs.vh"

module ccg_top (
  input  wire        mclk,
  input  wire        rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        fast_crystal_osc,
  input  wire        slow_crystal_osc,
  input  wire        pll_out,
  input  wire        fast_rc_osc_22m,
  input  wire        fast_rc_osc_48m,
  input  wire        slow_rc_osc,
  input  wire        divider_input_clock,
  input  wire        wakeup_irq,
  input  wire        wait_for_interrupt_insn,
  output reg         fast_xtal_enable,
  output reg         slow_xtal_enable,
  output reg         rc22_enable,
  output reg         rc48_enable,
  output reg         slow_rc_enable,
  output reg         pll_ref_select,
  output reg         pll_ref_clock,
  output wire        system_clock,
  output reg         cpu_clock,
  output wire        tick_external_clock,
  output reg         tick_clock,
  output reg  [3:0]  periph_clock,
  output wire        clock_output_pin,
  output reg         powerdown_active
);

  localparam ST_RUN  = 1'b0;
  localparam ST_DOWN = 1'b1;

  // Selection field to one of four source slots; unlisted codes fall
  // back to slot 3 so a bad write never leaves the clock dead
  function [1:0] sel_decode;
    input [2:0] code;
    begin
      case (code)
        3'h0:    sel_decode = 2'h0;
        3'h1:    sel_decode = 2'h1;
        3'h2:    sel_decode = 2'h2;
        default: sel_decode = 2'h3;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // Synchronisers for all pins from foreign domains

  wire [`CCG_NSYNC-1:0] raw_in;
  reg  [`CCG_NSYNC-1:0] sync1_q;
  reg  [`CCG_NSYNC-1:0] sync2_q;

  assign raw_in = {wakeup_irq, divider_input_clock, slow_rc_osc,
                   fast_rc_osc_48m, fast_rc_osc_22m, pll_out,
                   slow_crystal_osc, fast_crystal_osc};

  genvar gi;
  generate
    for (gi = 0; gi < `CCG_NSYNC; gi = gi + 1) begin : g_sync
      always @(posedge mclk or posedge rst) begin
        if (rst) begin
          sync1_q[gi] <= 1'b0;
          sync2_q[gi] <= 1'b0;
        end else begin
          sync1_q[gi] <= raw_in[gi];
          sync2_q[gi] <= sync1_q[gi];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // Registers

  reg  [8:0] pwr_q;
  reg  [6:0] sel0_q;
  reg  [2:0] tick_q;
  reg  [5:0] div_q;
  reg  [7:0] pclk_q;
  reg        state_q;
  reg        state_d;

  wire       wr_en;
  wire       setup;
  wire       mapped;

  assign setup   = psel && !penable;
  assign wr_en   = psel && penable && pwrite;
  // Registers always answer in the first access cycle
  assign pready  = 1'b1;
  assign mapped  = (paddr == `CCG_OFS_PWR)  || (paddr == `CCG_OFS_SEL0) ||
                   (paddr == `CCG_OFS_TICK) || (paddr == `CCG_OFS_DIV)  ||
                   (paddr == `CCG_OFS_PCLK) || (paddr == `CCG_OFS_STAT);
  assign pslverr = psel && penable && !mapped;

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      pwr_q  <= `CCG_PWR_RST;
      sel0_q <= `CCG_SEL0_RST;
      tick_q <= `CCG_TICK_RST;
      div_q  <= `CCG_DIV_RST;
      pclk_q <= `CCG_PCLK_RST;
    end else if (wr_en) begin
      case (paddr)
        `CCG_OFS_PWR:  pwr_q  <= pwdata[8:0];
        `CCG_OFS_SEL0: sel0_q <= pwdata[6:0];
        `CCG_OFS_TICK: tick_q <= pwdata[2:0];
        `CCG_OFS_DIV:  div_q  <= pwdata[5:0];
        `CCG_OFS_PCLK: pclk_q <= pwdata[7:0];
        default:       pwr_q  <= pwr_q;
      endcase
    end
  end

  // Read data is captured in the setup cycle, so it stands registered
  // for the whole access phase
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      prdata <= 32'h00000000;
    end else if (setup && !pwrite) begin
      case (paddr)
        `CCG_OFS_PWR:  prdata <= {23'h000000, pwr_q};
        `CCG_OFS_SEL0: prdata <= {25'h0000000, sel0_q};
        `CCG_OFS_TICK: prdata <= {29'h00000000, tick_q};
        `CCG_OFS_DIV:  prdata <= {26'h0000000, div_q};
        `CCG_OFS_PCLK: prdata <= {24'h000000, pclk_q};
        `CCG_OFS_STAT: prdata <= {23'h000000, state_q,
                                  sync2_q[7:0]};
        default:       prdata <= 32'h00000000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Power-down sequencer

  wire pd_armed;
  wire wake_evt;

  assign pd_armed = pwr_q[`CCG_PWR_PD_EN] && pwr_q[`CCG_PWR_WAIT];
  assign wake_evt = sync2_q[`CCG_SRC_WAKE];

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (wait_for_interrupt_insn && pd_armed)
          state_d = ST_DOWN;
      end
      ST_DOWN: begin
        if (wake_evt)
          state_d = ST_RUN;
      end
      default: state_d = ST_RUN;
    endcase
  end

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_q <= ST_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  wire in_down;
  assign in_down = (state_q == ST_DOWN);

  ////////////////////////////////////////////////////////////////////////
  // Oscillator enables and PLL reference

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      fast_xtal_enable <= 1'b0;
      slow_xtal_enable <= 1'b0;
      rc22_enable      <= 1'b1;
      rc48_enable      <= 1'b0;
      slow_rc_enable   <= 1'b1;
      pll_ref_select   <= 1'b0;
      pll_ref_clock    <= 1'b0;
      powerdown_active <= 1'b0;
    end else begin
      // Fast sources are forced off while asleep
      fast_xtal_enable <= pwr_q[`CCG_PWR_FXT_EN] && !in_down;
      rc22_enable      <= pwr_q[`CCG_PWR_RC22_EN] && !in_down;
      rc48_enable      <= pwr_q[`CCG_PWR_RC48_EN] && !in_down;
      // Slow sources ignore the sleep state
      slow_xtal_enable <= pwr_q[`CCG_PWR_SXT_EN];
      slow_rc_enable   <= pwr_q[`CCG_PWR_SRC_EN];
      pll_ref_select   <= sel0_q[`CCG_SEL_PLLREF];
      pll_ref_clock    <= sel0_q[`CCG_SEL_PLLREF] ?
                          sync2_q[`CCG_SRC_RC22] :
                          sync2_q[`CCG_SRC_FXT];
      powerdown_active <= in_down;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // System and tick clock selection

  wire [3:0] sys_src;
  wire [3:0] tick_src;
  wire [1:0] sys_sel;
  wire [1:0] tick_sel;

  assign sys_src  = {sync2_q[`CCG_SRC_RC22], sync2_q[`CCG_SRC_PLL],
                     sync2_q[`CCG_SRC_SXT], sync2_q[`CCG_SRC_FXT]};
  assign tick_src = {sync2_q[`CCG_SRC_RC22], sync2_q[`CCG_SRC_SRC],
                     sync2_q[`CCG_SRC_SXT], sync2_q[`CCG_SRC_FXT]};
  assign sys_sel  = sel_decode(sel0_q[`CCG_SEL_SYS_HI:`CCG_SEL_SYS_LO]);
  assign tick_sel = sel_decode(sel0_q[`CCG_SEL_TICK_HI:`CCG_SEL_TICK_LO]);

  ccg_gfmux u_sys_mux (
    .mclk      (mclk),
    .rst       (rst),
    .src_lvl   (sys_src),
    .sel       (sys_sel),
    .clk_out_q (system_clock)
  );

  ccg_gfmux u_tick_mux (
    .mclk      (mclk),
    .rst       (rst),
    .src_lvl   (tick_src),
    .sel       (tick_sel),
    .clk_out_q (tick_external_clock)
  );

  ////////////////////////////////////////////////////////////////////////
  // Gated CPU, tick and peripheral clocks

  // Low-speed source per peripheral
  wire [3:0] per_slow;
  wire [3:0] per_lvl;
  assign per_slow = pclk_q[7:4];

  generate
    for (gi = 0; gi < `CCG_NPER; gi = gi + 1) begin : g_per
      assign per_lvl[gi] = per_slow[gi] ? sync2_q[`CCG_SRC_SXT] :
                                          system_clock;
      always @(posedge mclk or posedge rst) begin
        if (rst)
          periph_clock[gi] <= 1'b0;
        else
          periph_clock[gi] <= pclk_q[gi] && per_lvl[gi] &&
                              (!in_down || per_slow[gi]);
      end
    end
  endgenerate

  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      cpu_clock  <= 1'b0;
      tick_clock <= 1'b0;
    end else begin
      // CPU stalls with its clock low while asleep
      cpu_clock  <= system_clock && !in_down;
      tick_clock <= tick_q[`CCG_TICK_CPU] ? (system_clock && !in_down) :
                                            tick_external_clock;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Frequency divider to the clock output pin

  ccg_fdiv u_fdiv (
    .mclk      (mclk),
    .rst       (rst),
    .in_lvl    (sync2_q[`CCG_SRC_DIVIN]),
    .enable    (div_q[`CCG_DIV_EN]),
    .bypass    (div_q[`CCG_DIV_BYP]),
    .ratio     (div_q[`CCG_DIV_N_HI:`CCG_DIV_N_LO]),
    .clk_out_q (clock_output_pin)
  );

endmodule // ccg_top

// ---- tb/cgpd_assertions.sv ----
module cgpd_assertions (
  input wire        mclk,
  input wire        rst,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire        pslverr,
  input wire        wakeup_irq,
  input wire        wait_for_interrupt_insn,
  input wire        fast_xtal_enable,
  input wire        rc22_enable,
  input wire        rc48_enable,
  input wire        divider_input_clock,
  input wire        clock_output_pin,
  input wire        powerdown_active
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] pw_q;
  logic [5:0] dv_q;
  logic [2:0] st_q;
  wire        wr = psel && penable && pwrite;
  // Shadow copies, since the checker only sees the bus
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      pw_q <= 9'h014;
      dv_q <= 6'h00;
      st_q <= 3'h0;
    end else begin
      if (wr && paddr == 12'h000)
        pw_q <= pwdata[8:0];
      if (wr && paddr == 12'h00c)
        dv_q <= pwdata[5:0];
      // Cycles since the last divider write, saturating
      if (wr && paddr == 12'h00c)
        st_q <= 3'h0;
      else if (st_q != 3'h7)
        st_q <= st_q + 3'h1;
    end
  end
  ////////////////////////////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  a_apb_answer: assert property (psel && penable |-> pready &&
    pslverr == (paddr > 12'h014 || paddr[1:0] != 2'b00))
    else $error("apb answer wrong");
  a_pd_entry: assert property (!powerdown_active &&
    wait_for_interrupt_insn && pw_q[8:7] == 2'b11 && !wakeup_irq
    |-> ##2 powerdown_active)
    else $error("power-down not entered");
  a_pd_cause: assert property ($rose(powerdown_active) |->
    $past(wait_for_interrupt_insn, 2) && pw_q[8:7] == 2'b11)
    else $error("power-down without cause");
  a_fast_off: assert property (powerdown_active |->
    !fast_xtal_enable && !rc22_enable && !rc48_enable)
    else $error("fast oscillator left on");
  a_wake_exit: assert property (powerdown_active && wakeup_irq [*3]
    |-> ##[0:3] !powerdown_active)
    else $error("wake ignored");
  a_pd_hold: assert property ($fell(powerdown_active) |->
    $past(wakeup_irq, 3) || $past(wakeup_irq, 4) || $past(wakeup_irq, 5))
    else $error("left power-down unwoken");
  a_div_bypass: assert property (dv_q[5:4] == 2'b11 &&
    st_q >= 3'h5 |-> clock_output_pin == $past(divider_input_clock, 3))
    else $error("bypass output wrong");
  a_div_parked: assert property (!dv_q[4] && !dv_q[5] &&
    !$past(dv_q[4]) && !$past(dv_q[4], 2) && !clock_output_pin
    |=> !clock_output_pin)
    else $error("stopped divider rose");
endmodule // cgpd_assertions

bind ccg_top cgpd_assertions u_chk (
  .mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
  .pslverr, .wakeup_irq, .wait_for_interrupt_insn, .fast_xtal_enable,
  .rc22_enable, .rc48_enable, .divider_input_clock, .clock_output_pin,
  .powerdown_active
);

// ---- tb/tb_clock_gen_powerdown_divider.sv ----
module tb_clock_gen_powerdown_divider;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HP [7] = '{5, 7, 9, 11, 13, 17, 6};
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic        wakeup_irq = 1'b0;
  logic        wait_for_interrupt_insn = 1'b0;
  logic [6:0]  sl = 7'h00;
  int          dv [7] = '{default: 0};
  int          error_cnt = 0;
  int          checks_done = 0;
  wire  [31:0] prdata;
  wire  [3:0]  periph_clock;
  wire         pready, pslverr, fast_xtal_enable, slow_xtal_enable;
  wire         rc22_enable, rc48_enable, slow_rc_enable, pll_ref_select;
  wire         pll_ref_clock, system_clock, cpu_clock, tick_external_clock;
  wire         tick_clock, clock_output_pin, powerdown_active;
  wire  [5:0]  obs = {periph_clock[1:0], clock_output_pin, pll_ref_clock,
                      tick_clock, system_clock};
  always #2 mclk = ~mclk;
  // Sources kept well under mclk/4 so the synchronisers see them
  always @(posedge mclk)
    foreach (dv[i])
      if (dv[i] == HP[i] - 1) begin
        dv[i] <= 0;
        sl[i] <= ~sl[i];
      end else
        dv[i] <= dv[i] + 1;
  ccg_top dut (
    .mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .fast_crystal_osc(sl[0]), .slow_crystal_osc(sl[1]),
    .pll_out(sl[2]), .fast_rc_osc_22m(sl[3]), .fast_rc_osc_48m(sl[4]),
    .slow_rc_osc(sl[5]), .divider_input_clock(sl[6]), .wakeup_irq,
    .wait_for_interrupt_insn, .fast_xtal_enable, .slow_xtal_enable,
    .rc22_enable, .rc48_enable, .slow_rc_enable, .pll_ref_select,
    .pll_ref_clock, .system_clock, .cpu_clock, .tick_external_clock,
    .tick_clock, .periph_clock, .clock_output_pin, .powerdown_active
  );
  ////////////////////////////////////////////////////////////////
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [32:0] r);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 40);
    if (n >= 40) begin
      error_cnt++;
      conclude();
    end
    r = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [32:0] r;
    apb(1'b1, a, d, r);
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] exp);
    logic [32:0] r;
    apb(1'b0, a, 32'h0, r);
    chk(r, exp);
  endtask
  // Rising edges of obs[i] and the cycles between the first two
  task automatic meas(input int i, input int lim, output int t,
                      output int n);
    logic p;
    t = 0;
    n = 0;
    p = 1'b1;
    for (int k = 0; k < lim && n < 2; k++) begin
      @(posedge mclk);
      if (obs[i] === 1'b1 && p === 1'b0) begin
        n++;
        t = k - t;
      end
      p = obs[i];
    end
  endtask
  // First window may hold a switch-over, so only the second counts
  task automatic per(input int i, input int exp);
    int t, n;
    meas(i, 3000, t, n);
    meas(i, 3000, t, n);
    if (n < 2) begin
      error_cnt++;
      conclude();
    end
    chk(t, exp);
  endtask
  task automatic pulse();
    @(posedge mclk);
    wait_for_interrupt_insn <= 1'b1;
    @(posedge mclk);
    wait_for_interrupt_insn <= 1'b0;
    repeat (4) @(posedge mclk);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_regs();
    rd(12'h000, 33'h014);
    rd(12'h004, 33'h007);
    rd(12'h008, 33'h004);
    rd(12'h00c, 33'h000);
    rd(12'h010, 33'h000);
    rd(12'h018, 33'h1_0000_0000);
    wr(12'h010, 32'hffff_ffff);
    rd(12'h010, 33'h0ff);
    $display("regs done");
  endtask
  task automatic t_mux();
    int sys [5] = '{5, 7, 9, 11, 11};
    int tck [4] = '{5, 7, 17, 11};
    wr(12'h008, 32'h0);
    for (int s = 0; s < 5; s++) begin
      wr(12'h004, 32'(s));
      per(0, 2 * sys[s]);
    end
    for (int s = 0; s < 4; s++) begin
      wr(12'h004, 32'(3 + 8 * s));
      per(1, 2 * tck[s]);
    end
    wr(12'h008, 32'h4);
    per(1, 22);
    wr(12'h004, 32'h43);
    per(2, 22);
    chk(pll_ref_select, 1);
    wr(12'h004, 32'h03);
    per(2, 10);
    chk(pll_ref_select, 0);
    $display("mux done");
  endtask
  task automatic t_div();
    int t, n;
    wr(12'h00c, 32'h10);
    per(3, 24);
    wr(12'h00c, 32'h13);
    per(3, 192);
    wr(12'h00c, 32'h33);
    per(3, 12);
    wr(12'h00c, 32'h13);
    per(3, 192);
    wr(12'h00c, 32'h03);
    meas(3, 600, t, n);
    chk(n, 0);
    chk(obs[3], 0);
    $display("div done");
  endtask
  task automatic t_pd();
    int t, n;
    wr(12'h010, 32'h13);
    wr(12'h000, 32'h09f);
    pulse();
    chk(powerdown_active, 0);
    wr(12'h000, 32'h11f);
    pulse();
    chk(powerdown_active, 0);
    wr(12'h000, 32'h19f);
    pulse();
    chk(powerdown_active, 1);
    chk({fast_xtal_enable, rc22_enable, rc48_enable}, 0);
    chk({slow_xtal_enable, slow_rc_enable}, 3);
    chk({cpu_clock, periph_clock[3:2]}, 0);
    per(4, 14);
    meas(5, 200, t, n);
    chk(n, 0);
    chk(powerdown_active, 1);
    wakeup_irq <= 1'b1;
    for (n = 0; n < 20 && powerdown_active !== 1'b0; n++)
      @(posedge mclk);
    chk(n < 20, 1);
    wakeup_irq <= 1'b0;
    repeat (4) @(posedge mclk);
    chk({fast_xtal_enable, rc22_enable, rc48_enable}, 7);
    $display("power-down done");
  endtask
  initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    t_regs();
    t_mux();
    t_div();
    t_pd();
    conclude();
  end
endmodule // tb_clock_gen_powerdown_divider
